// file: spi_port.sv
`include "spi_port_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module spi_port (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Register port.
   input wire spi_port_pkg::reg_req_t req,
   output logic [7:0] rdata,
   // Timer pulse, same clock domain.
   input wire logic timer_two_tick,
   // Serial pins.
   input wire logic sck_in,
   input wire logic sdi_in,
   input wire logic ss_n_in,
   output logic sck_out,
   output logic sck_oe,
   output logic sdo_out,
   output logic sdo_oe,
   output logic pins_owned
);
   import spi_port_pkg::*;

   logic smp_reg, smp_next, cke_reg, cke_next, bf_reg, bf_next;
   logic irq_reg, irq_next, sck_reg, sck_next, sdo_reg, sdo_next;
   logic sck_last_reg, sck_oe_reg, sdo_oe_reg, owned_reg;
   logic [7:0] control_reg, control_next, buffer_reg, buffer_next;
   logic [7:0] shift_reg, shift_next, rdata_reg, rdata_next;
   logic [5:0] div_reg, div_next;
   logic [4:0] tick_reg, tick_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   xfer_state_t state_reg, state_next;
   logic sck_s, sdi_s, ss_n_s;

   // Pins from the far side pass two flops before anything reads them.
   pin_sync #(
      .WIDTH(3)
   ) sync_u (
      .clock(clock),
      .reset(reset),
      .pins({sck_in, sdi_in, ss_n_in}),
      .synced({sck_s, sdi_s, ss_n_s})
   );

   // Configuration decode.
   wire enable = control_reg[`CTRL_EN];
   wire clock_idle_level = control_reg[`CTRL_CKP];
   wire [3:0] mode = control_reg[`CTRL_MODE_HI:0];
   wire is_master = enable && (mode[3:2] == 2'b00);
   wire is_slave = enable && (mode == `MODE_SLAVE_SS || mode == `MODE_SLAVE_NOSS);
   wire ss_ctrl = (mode == `MODE_SLAVE_SS);
   wire ss_block = is_slave && ss_ctrl && ss_n_s;
   wire s_live = is_slave && !ss_block;

   // Master bit clock: divider half periods, or one edge per timer pulse.
   wire [5:0] half_len = (mode == `MODE_DIV4) ? `HALF_DIV4 :
                         (mode == `MODE_DIV16) ? `HALF_DIV16 : `HALF_DIV64;
   wire running = (state_reg == ST_RUN);
   wire tmr_mode = (mode == `MODE_TIMER_TWO_OUTPUT);
   wire half_tick = running && (tmr_mode ? timer_two_tick :
                                (div_reg == half_len - 6'h01));

   // Master sample and change points along the sixteen clock edges.
   // Even steps are leading edges, odd steps trailing; step sixteen closes the byte.
   wire [4:0] t = tick_reg;
   wire m_sample = half_tick && (cke_reg ?
                   (smp_reg ? t[0] : (!t[0] && t != `LAST_TICK)) :
                   (smp_reg ? (!t[0] && t != 5'h00) : t[0]));
   wire m_change = half_tick && (cke_reg ? (t[0] && t != `LAST_EDGE) :
                                 (!t[0] && t != `LAST_TICK));
   wire m_done = half_tick && (t == `LAST_TICK);

   // Slave edges seen on the synchronised clock, relative to the idle level.
   wire sck_moved = (sck_s != sck_last_reg);
   wire lead = sck_moved && (sck_s != clock_idle_level);
   wire trail = sck_moved && (sck_s == clock_idle_level);
   wire s_sample = s_live && (cke_reg ? lead : trail);
   wire s_change = s_live && (cke_reg ? trail : lead);
   wire s_done = s_sample && (bit_cnt_reg == `LAST_BIT);

   // Shared shift path for both roles.
   wire sample_now = m_sample || s_sample;
   wire change_now = m_change || s_change;
   wire [7:0] shifted = {shift_reg[6:0], sdi_s};
   wire [7:0] rx_byte = sample_now ? shifted : shift_reg;
   wire busy = running || (is_slave && bit_cnt_reg != 3'h0);
   wire xfer_done = m_done || s_done;
   wire overflow = s_done && bf_reg;
   wire load_rx = xfer_done && !overflow;

   // Register port decode.
   wire wr_status = req.wr && (req.addr == `ADDR_STATUS);
   wire wr_control = req.wr && (req.addr == `ADDR_CONTROL);
   wire wr_irq = req.wr && (req.addr == `ADDR_IRQ);
   wire buf_write = req.wr && (req.addr == `ADDR_DATA);
   wire buf_read = req.rd && (req.addr == `ADDR_DATA);
   wire write_ok = buf_write && !busy;
   wire collision = buf_write && busy;

   // Status read view: only the two phase bits and buffer full are live.
   // The stop bit has no source in this mode, so it reads zero and is
   // therefore also clear whenever the port is disabled.
   wire [7:0] status_view = {smp_reg, cke_reg, 1'b0, 1'b0,
                             3'b000, bf_reg};

   // Read mux; the shift register itself has no address.
   always_comb begin
      if (!req.rd) begin
         rdata_next = 8'h00;
      end else if (req.addr == `ADDR_STATUS) begin
         rdata_next = status_view;
      end else if (req.addr == `ADDR_CONTROL) begin
         rdata_next = control_reg;
      end else if (req.addr == `ADDR_DATA) begin
         rdata_next = buffer_reg;
      end else begin
         rdata_next = {7'h00, irq_reg};
      end
   end

   // Software field updates; a hardware set in the same cycle wins the clear.
   always_comb begin
      smp_next = wr_status ? req.wdata[`STAT_SMP] : smp_reg;
      cke_next = wr_status ? req.wdata[`STAT_CKE] : cke_reg;
      bf_next = load_rx ? 1'b1 : (buf_read ? 1'b0 : bf_reg);
      irq_next = xfer_done ? 1'b1 : ((wr_irq && !req.wdata[`IRQ_FLAG]) ? 1'b0 : irq_reg);
      control_next = wr_control ? req.wdata : control_reg;
      if (collision) begin
         control_next[`CTRL_WRITE_COLLISION_FLAG] = 1'b1;
      end
      if (overflow) begin
         control_next[`CTRL_OVR] = 1'b1;
      end
   end

   // Data path: one write fills both buffer and shift register.
   always_comb begin
      buffer_next = load_rx ? rx_byte : buffer_reg;
      shift_next = shift_reg;
      sdo_next = sdo_reg;
      if (write_ok) begin
         buffer_next = req.wdata;
         shift_next = req.wdata;
         sdo_next = req.wdata[7];
      end else begin
         if (sample_now) begin
            shift_next = shifted;
         end
         if (change_now) begin
            sdo_next = sample_now ? shift_reg[6] : shift_reg[7];
         end
      end
   end

   // Master sequencer and clock generator.
   always_comb begin
      state_next = state_reg;
      tick_next = 5'h00;
      div_next = 6'h00;
      sck_next = clock_idle_level;
      case (state_reg)
         ST_IDLE: begin
            if (write_ok && is_master) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            sck_next = sck_reg;
            tick_next = half_tick ? tick_reg + 5'h01 : tick_reg;
            div_next = (half_tick || tmr_mode) ? 6'h00 : div_reg + 6'h01;
            if (half_tick && t != `LAST_TICK) begin
               sck_next = ~sck_reg;
            end
            if (m_done || !is_master) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Slave bit counter; a raised select in MODE_SLAVE_SS, or disable, forces it back to zero.
   always_comb begin
      bit_cnt_next = bit_cnt_reg;
      if (!s_live) begin
         bit_cnt_next = 3'h0;
      end else if (s_sample) begin
         bit_cnt_next = bit_cnt_reg + 3'h1;
      end
   end

   // Configuration and flag registers.
   always_ff @(posedge clock) begin
      if (reset) begin
         smp_reg <= 1'(`STATUS_RST >> `STAT_SMP);
         cke_reg <= 1'b0;
         bf_reg <= 1'b0;
         irq_reg <= 1'b0;
         control_reg <= `CONTROL_RST;
      end else begin
         smp_reg <= smp_next;
         cke_reg <= cke_next;
         bf_reg <= bf_next;
         irq_reg <= irq_next;
         control_reg <= control_next;
      end
   end

   // Data and sequencing registers.
   always_ff @(posedge clock) begin
      if (reset) begin
         buffer_reg <= `BUFFER_RST;
         shift_reg <= `BUFFER_RST;
         state_reg <= ST_IDLE;
         tick_reg <= 5'h00;
         div_reg <= 6'h00;
         bit_cnt_reg <= 3'h0;
         sck_last_reg <= 1'b0;
      end else begin
         buffer_reg <= buffer_next;
         shift_reg <= shift_next;
         state_reg <= state_next;
         tick_reg <= tick_next;
         div_reg <= div_next;
         bit_cnt_reg <= bit_cnt_next;
         sck_last_reg <= sck_s;
      end
   end

   // Pin drivers are registered so every output comes from a flop.
   // Output enables drop while disabled, returning the pins to general use.
   always_ff @(posedge clock) begin
      if (reset) begin
         sck_reg <= 1'b0;
         sdo_reg <= 1'b0;
         sck_oe_reg <= 1'b0;
         sdo_oe_reg <= 1'b0;
         owned_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         sck_reg <= sck_next;
         sdo_reg <= sdo_next;
         sck_oe_reg <= is_master;
         sdo_oe_reg <= is_master || s_live;
         owned_reg <= enable;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign sck_out = sck_reg;
   assign sck_oe = sck_oe_reg;
   assign sdo_out = sdo_reg;
   assign sdo_oe = sdo_oe_reg;
   assign pins_owned = owned_reg;

   // Helper for checking: clock toggles within the current master transfer.
   logic [4:0] edges_reg;
   always_ff @(posedge clock) begin
      if (reset || state_reg == ST_IDLE) begin
         edges_reg <= 5'h00;
      end else if (sck_next != sck_reg) begin
         edges_reg <= edges_reg + 5'h01;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence accepted_write_s;
      write_ok && is_master && state_reg == ST_IDLE;
   endsequence

   sequence rx_loaded_s;
      bf_reg && irq_reg && buffer_reg == $past(rx_byte);
   endsequence

   write_starts_a: assert property (accepted_write_s |=> running ##1 running)
      else $error("master did not start on buffer write");

   write_loads_a: assert property (write_ok |=> buffer_reg == $past(req.wdata)
                                   && shift_reg == $past(req.wdata))
      else $error("buffer write did not load both registers");

   collision_flag_a: assert property (collision |=> control_reg[`CTRL_WRITE_COLLISION_FLAG]
                                      && $stable(buffer_reg))
      else $error("busy write not discarded or collision not flagged");

   done_loads_a: assert property (load_rx |=> rx_loaded_s)
      else $error("completed byte not moved to buffer");

   read_clears_a: assert property (buf_read && !load_rx |=> !bf_reg)
      else $error("buffer read did not clear buffer full");

   overflow_slave_a: assert property ($rose(control_reg[`CTRL_OVR]) && !$past(wr_control)
                                      |-> $past(is_slave) && $stable(buffer_reg))
      else $error("overflow raised outside slave operation");

   eight_pulses_a: assert property (m_done |-> edges_reg == 5'h10)
      else $error("master transfer did not give eight clock pulses");

   idle_level_a: assert property (state_reg == ST_IDLE && is_master ##1
                                  state_reg == ST_IDLE |-> sck_out == $past(clock_idle_level))
      else $error("serial clock not at idle level");

   select_reset_a: assert property (ss_block |=> bit_cnt_reg == 3'h0 && !sdo_oe)
      else $error("high select did not reset slave");

endmodule : spi_port

`default_nettype wire

// file: spi_port_cfg.svh
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// Register addresses on the plain register port.
`define ADDR_STATUS 2'h0
`define ADDR_CONTROL 2'h1
`define ADDR_DATA 2'h2
`define ADDR_IRQ 2'h3

// Status register fields.
`define STAT_SMP 7
`define STAT_CKE 6
`define STAT_STOP 4
`define STAT_BF 0

// Control register fields.
`define CTRL_WRITE_COLLISION_FLAG 7
`define CTRL_OVR 6
`define CTRL_EN 5
`define CTRL_CKP 4
`define CTRL_MODE_HI 3

// Interrupt flag register field.
`define IRQ_FLAG 0

// Reset values.
`define STATUS_RST 8'h00
`define CONTROL_RST 8'h00
`define BUFFER_RST 8'h00

// Mode select codes.
`define MODE_DIV4 4'h0
`define MODE_DIV16 4'h1
`define MODE_DIV64 4'h2
`define MODE_TIMER_TWO_OUTPUT 4'h3
`define MODE_SLAVE_SS 4'h4
`define MODE_SLAVE_NOSS 4'h5

// Half serial clock periods in system clocks for each divider.
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20

// Master sequencing: sixteen clock edges, then one closing step.
`define LAST_TICK 5'h10
`define LAST_EDGE 5'h0f
`define LAST_BIT 3'h7

`endif

// file: spi_port_pkg.sv
package spi_port_pkg;

   // One register port request, as the software side presents it.
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Master transfer sequencer.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } xfer_state_t;

endpackage : spi_port_pkg

// file: pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for pins that arrive from outside the clock domain.
module pin_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Pin side and synchronised side.
   input wire logic [WIDTH-1:0] pins,
   output logic [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] meta_reg;

   // Only the second stage reads the first, to keep metastability contained.
   always_ff @(posedge clock) begin
      if (reset) begin
         meta_reg <= '0;
         synced <= '0;
      end else begin
         meta_reg <= pins;
         synced <= meta_reg;
      end
   end

endmodule : pin_sync

`default_nettype wire

// file: spi_peer.sv
`timescale 1ns/10ps
`default_nettype none

// Far-side SPI device: one byte shift in and out on whatever clock the line carries.
module spi_peer (
   // Line side.
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // Frame setup.
   input wire logic cpol,
   input wire logic cke,
   input wire logic load,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   int idx;

   initial miso = 1'b0;

   // With the leading-edge sample the first bit must stand before any clock edge.
   always @(posedge load) begin
      rx_byte = 8'h00;
      idx = cke ? 1 : 0;
      miso = cke ? tx_byte[7] : ~miso;
   end

   // Sample on one edge, change on the other; a spent byte leaves a toggling line.
   always @(sck) begin
      if ((sck !== cpol) == cke) begin
         rx_byte = {rx_byte[6:0], mosi};
      end else if (idx < 8) begin
         miso = tx_byte[7 - idx];
         idx++;
      end else begin
         miso = ~miso;
      end
   end
endmodule : spi_peer

`default_nettype wire

// file: spi_master_slave_port_tb.sv
`include "spi_port_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module spi_master_slave_port_tb;
   import spi_port_pkg::*;

   logic clock, reset, tick, tb_sck, ss_n, load, watch, first, sck_q, cpol_q, cke_q;
   logic sck_out, sck_oe, sdo_out, sdo_oe, pins_owned, miso;
   logic [7:0] rdata, ptx, peer_rx, gap, edges, exp_half;
   logic [2:0] tcnt;
   reg_req_t req;
   int bad_count, tests_run;
   wire sck_line = sck_oe ? sck_out : tb_sck;

   spi_port dut_u (.clock(clock), .reset(reset), .req(req), .rdata(rdata),
      .timer_two_tick(tick), .sck_in(sck_line), .sdi_in(miso), .ss_n_in(ss_n),
      .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .pins_owned(pins_owned));
   spi_peer peer_u (.sck(sck_line), .mosi(sdo_out), .miso(miso), .cpol(cpol_q),
      .cke(cke_q), .load(load), .tx_byte(ptx), .rx_byte(peer_rx));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Timer pulse every sixth clock, so a timer-driven half period is six clocks.
   always @(posedge clock) begin
      tcnt <= (tcnt == 3'd5) ? 3'd0 : tcnt + 3'd1;
      tick <= (tcnt == 3'd5);
   end

   // The first edge of a transfer is skipped, since idle time before it is arbitrary.
   always @(posedge clock) begin
      sck_q <= sck_out;
      if (sck_oe && sck_out !== sck_q) begin
         if (watch && !first) begin
            check("sck half period", gap, exp_half);
         end
         first <= !watch;
         edges <= edges + 8'd1;
         gap <= 8'd1;
      end else begin
         if (!watch) first <= 1'b1;
         gap <= gap + 8'd1;
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= {a, d, 1'b1, 1'b0};
      @(posedge clock);
      req <= '0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock);
      req <= {a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      req <= '0;
      #1 d = rdata;
   endtask : rd

   task automatic reload;
      ptx = $urandom;
      load <= 1'b1;
      @(posedge clock);
      load <= 1'b0;
   endtask : reload

   task automatic cfg(input logic [3:0] m, input logic cp, input logic ck, input logic input_sample_phase);
      cpol_q = cp;
      cke_q = ck;
      tb_sck <= cp;
      // Disable first, so a new idle level cannot reach a live slave as a false edge.
      wr(`ADDR_CONTROL, 8'h00);
      wr(`ADDR_CONTROL, {3'b001, cp, m});
      wr(`ADDR_STATUS, {input_sample_phase, ck, 6'h00});
      wr(`ADDR_IRQ, 8'h00);
      repeat (4) @(posedge clock);
      reload();
   endtask : cfg

   task automatic wait_irq;
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < 400 && v[0] !== 1'b1; i++) rd(`ADDR_IRQ, v);
      check("irq flag", v, 8'h01);
      if (v[0] !== 1'b1) finish_test();
   endtask : wait_irq

   task automatic pulses(input int n);
      repeat (n) begin
         tb_sck <= ~cpol_q;
         repeat (10) @(posedge clock);
         tb_sck <= cpol_q;
         repeat (10) @(posedge clock);
      end
   endtask : pulses

   task automatic master_run(input logic [3:0] m, input logic cp, input logic ck,
         input logic input_sample_phase, input logic rd_back);
      logic [7:0] tx, v, e0;
      watch <= 1'b0;
      cfg(m, cp, ck, input_sample_phase);
      tx = $urandom;
      check("sck idle", {7'h00, sck_out}, {7'h00, cp});
      check("pins owned", {7'h00, pins_owned}, 8'h01);
      exp_half = (m == 0) ? 8'd2 : (m == 1) ? 8'd8 : (m == 2) ? 8'd32 : 8'd6;
      watch <= 1'b1;
      e0 = edges;
      wr(`ADDR_DATA, tx);
      wr(`ADDR_DATA, ~tx);
      wait_irq();
      check("edge count", edges - e0, 8'd16);
      check("sck idle after", {7'h00, sck_out}, {7'h00, cp});
      check("peer byte", peer_rx, tx);
      rd(`ADDR_STATUS, v);
      check("buffer full", v, {input_sample_phase, ck, 6'h01});
      rd(`ADDR_CONTROL, v);
      check("master control", v, {3'b101, cp, m});
      if (rd_back) begin
         rd(`ADDR_DATA, v);
         if (m != 4'h0) check("master rx", v, ptx);
         rd(`ADDR_STATUS, v);
         check("buffer emptied", v, {input_sample_phase, ck, 6'h00});
      end
   endtask : master_run

   task automatic slave_run(input logic [3:0] m, input logic cp, input logic ck,
         input logic abort);
      logic [7:0] tx, v, p1;
      ss_n <= 1'b1;
      rd(`ADDR_DATA, v);
      cfg(m, cp, ck, 1'b0);
      tx = $urandom;
      wr(`ADDR_DATA, tx);
      if (abort) begin
         ss_n <= 1'b0;
         pulses(3);
         wr(`ADDR_DATA, ~tx);
         ss_n <= 1'b1;
         repeat (6) @(posedge clock);
         check("sdo released", {7'h00, sdo_oe}, 8'h00);
         wr(`ADDR_DATA, tx);
         reload();
      end
      ss_n <= 1'b0;
      pulses(8);
      repeat (10) @(posedge clock);
      p1 = ptx;
      check("slave peer byte", peer_rx, tx);
      rd(`ADDR_IRQ, v);
      check("slave irq", v, 8'h01);
      rd(`ADDR_STATUS, v);
      check("slave full", v, {1'b0, ck, 6'h01});
      reload();
      pulses(8);
      repeat (10) @(posedge clock);
      ss_n <= 1'b1;
      rd(`ADDR_CONTROL, v);
      check("overflow", v, {abort, 2'b11, cp, m});
      rd(`ADDR_DATA, v);
      check("slave rx", v, p1);
   endtask : slave_run

   // Reset, register access, every master rate and phase, then the slave modes.
   initial begin
      logic [7:0] v;
      req = '0;
      reset = 1'b1;
      {tick, tb_sck, load, watch, sck_q, cpol_q, cke_q} = '0;
      {tcnt, gap, edges, exp_half, ptx} = '0;
      ss_n = 1'b1;
      first = 1'b1;
      void'($urandom(32'h0d8d));
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      rd(`ADDR_STATUS, v);
      check("status reset", v, 8'h00);
      rd(`ADDR_CONTROL, v);
      check("control reset", v, 8'h00);
      wr(`ADDR_STATUS, 8'hff);
      rd(`ADDR_STATUS, v);
      check("status access", v, 8'hc0);
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 4; k++) begin
            master_run(4'(m), k[1], k[0], (m != 0) ? 1'($urandom) : 1'b0, k != 1);
         end
      end
      slave_run(`MODE_SLAVE_SS, 1'b0, 1'b1, 1'b1);
      slave_run(`MODE_SLAVE_SS, 1'b1, 1'b1, 1'b0);
      slave_run(`MODE_SLAVE_NOSS, 1'b0, 1'b0, 1'b0);
      slave_run(`MODE_SLAVE_NOSS, 1'b1, 1'b0, 1'b0);
      wr(`ADDR_CONTROL, 8'h00);
      repeat (2) @(posedge clock);
      check("pins released", {5'h00, pins_owned, sck_oe, sdo_oe}, 8'h00);
      rd(`ADDR_STATUS, v);
      check("stop bit", v & 8'h10, 8'h00);
      finish_test();
   end
endmodule : spi_master_slave_port_tb

`default_nettype wire
